// >>> core/ctcs_pkg.sv
// Purpose: Constants, types and register map of the card transfer cycle sequencer.
// Assumes: pclk at 125 MHz; times below are kept in ns and turned into cycle counts.
// Notes: Contract

package ctcs_pkg;

	// Clock period
	localparam int CLK_NS      = 8;
	// Times in ns, figures as given
	localparam int T_DECODE_NS = 9000;
	localparam int T_COND_NS   = 2000;
	localparam int T_COLST_NS  = 16000;
	localparam int T_ASM_NS    = 48000;
	localparam int T_ASM_ROW_NS = 288000;
	localparam int T_DIS_NS    = 192000;
	localparam int T_DIS_ROW_NS = 1152000;
	localparam int T_SCAN_NS   = 1280000;
	localparam int T_TM_TR_NS  = 2560000;
	localparam int T_TM_IMG_NS = 5120000;
	// Cycle counts; decode and condition times round down, the rest round up
	localparam int DECODE_CYC  = T_DECODE_NS / CLK_NS;
	localparam int COND_CYC    = T_COND_NS / CLK_NS;
	localparam int COLST_CYC   = (T_COLST_NS + CLK_NS - 1) / CLK_NS;
	localparam int ASM_CYC     = (T_ASM_NS + CLK_NS - 1) / CLK_NS;
	localparam int ASM_ROW_CYC = (T_ASM_ROW_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIS_CYC     = (T_DIS_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIS_ROW_CYC = (T_DIS_ROW_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCAN_CYC    = (T_SCAN_NS + CLK_NS - 1) / CLK_NS;
	localparam int TM_TR_CYC   = (T_TM_TR_NS + CLK_NS - 1) / CLK_NS;
	localparam int TM_IMG_CYC  = (T_TM_IMG_NS + CLK_NS - 1) / CLK_NS;

	// Words per card by mode
	localparam logic [5:0] WORDS_TR  = 6'd14;
	localparam logic [5:0] WORDS_COL = 6'd27;
	localparam logic [5:0] WORDS_ROW = 6'd36;

	// Register byte addresses
	localparam logic [11:0] REG_FUNC   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_CTRL   = 12'h008;

	// Function codes in FUNC[2:0]; FUNC[3] interrupt, FUNC[5:4] mode
	localparam logic [2:0] FN_FILL   = 3'h1;
	localparam logic [2:0] FN_NOTRIP = 3'h2;
	localparam logic [2:0] FN_TRIP   = 3'h3;
	localparam logic [2:0] FN_COND   = 3'h4;
	localparam logic [2:0] FN_PUNCH  = 3'h5;

	// Status codes
	localparam logic [2:0] SC_NONE     = 3'h0;
	localparam logic [2:0] SC_IMPROPER = 3'h1;
	localparam logic [2:0] SC_COND     = 3'h2;
	localparam logic [2:0] SC_IN_DONE  = 3'h3;
	localparam logic [2:0] SC_OUT_DONE = 3'h4;

	// Output transfer areas after clear; areas skipped after a recovered error
	localparam logic [1:0] AREAS_ALL  = 2'd3;
	localparam logic [1:0] SKIP_RECOV = 2'd2;

	// Card modes
	typedef enum logic [1:0] {
		CTCS_TRANSLATE  = 2'd0,
		COLUMN_IMAGE_MODE = 2'd1,
		ROW_IMAGE_MODE  = 2'd2
	} ctcs_mode_t;

	// Sequencer states, one-hot
	typedef enum logic [8:0] {
		S_IDLE     = 9'b0_0000_0001,
		S_DECODE   = 9'b0_0000_0010,
		S_IN_WAIT  = 9'b0_0000_0100,
		S_IN_ASM   = 9'b0_0000_1000,
		S_IN_REQ   = 9'b0_0001_0000,
		S_CP_COND  = 9'b0_0010_0000,
		S_OUT_WAIT = 9'b0_0100_0000,
		S_OUT_REQ  = 9'b0_1000_0000,
		S_OUT_DIS  = 9'b1_0000_0000
	} ctcs_st_t;

	// Mechanism status toward the sequencer
	typedef struct packed {
		logic in_area_full;  // An input transfer area holds a card
		logic sense_empty;   // Input sense area holds nothing
		logic read_active;   // Read portion of feed/read running
		logic fr_pending;    // Feed/read or move still owed
		logic pv_active;     // Punch/verify cycle running
		logic tm_start;      // Translate/move begins (pulse)
		logic col_store;     // Column being stored (pulse)
		logic row_scan;      // Row scan begins (pulse)
		logic pv_done;       // Punch/verify finished (pulse)
		logic pv_err;        // Error seen in that cycle
		logic pv_first;      // It was the first attempt
		logic auto_rec;      // Automatic recovery active
		logic mclr;          // Master clear of subsystem or punch
	} ctcs_mech_t;

	// Whole sequencer state
	typedef struct packed {
		ctcs_st_t    st;
		logic [19:0] cnt;
		logic [19:0] tm_cnt;
		logic [19:0] col_cnt;
		logic [19:0] scan_cnt;
		logic [2:0]  func;
		logic        fintr;
		logic [1:0]  fmode;
		logic        prev_fill;
		logic        fed;
		logic [1:0]  punch_mode;
		logic [1:0]  rd_mode;
		logic [5:0]  word_cnt;
		logic [1:0]  free;
		logic [1:0]  skip;
		logic [2:0]  status;
		logic        irq;
		logic        in_req;
		logic        out_req;
		logic [31:0] in_data;
		logic [31:0] out_data;
		logic        out_we;
		logic        feed_req;
		logic        punch_feed;
		logic [31:0] prdata;
		logic        pslverr;
	} ctcs_state_t;

endpackage

// >>> core/ctcs_top.sv
// Purpose: Card transfer cycle sequencer: input and output transfer scheduling.
// Assumes: Mechanism inputs synchronous to pclk; buffer memory answers at once.
// Notes: Functions are issued over APB; words move on the channel ports.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps

module ctcs_top #(
	parameter logic [19:0] ASM_TR_CYC  = 20'(ctcs_pkg::ASM_CYC),
	parameter logic [19:0] ASM_RW_CYC  = 20'(ctcs_pkg::ASM_ROW_CYC),
	parameter logic [19:0] DIS_TR_CYC  = 20'(ctcs_pkg::DIS_CYC),
	parameter logic [19:0] DIS_RW_CYC  = 20'(ctcs_pkg::DIS_ROW_CYC),
	parameter logic [19:0] SCAN_BLK_CYC = 20'(ctcs_pkg::SCAN_CYC),
	parameter logic [19:0] TM_T_CYC    = 20'(ctcs_pkg::TM_TR_CYC),
	parameter logic [19:0] TM_I_CYC    = 20'(ctcs_pkg::TM_IMG_CYC)
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Processor channel
	output logic                    input_word_request,
	output logic [31:0]             input_word_data,
	input  wire logic               input_word_ack,
	output logic                    output_word_request,
	input  wire logic               output_word_ack,
	input  wire logic [31:0]        output_word_data,
	output logic                    host_interrupt_line,
	// Mechanism and buffer memory
	input  wire ctcs_pkg::ctcs_mech_t mech,
	input  wire logic [31:0]        in_buf_word,
	output logic [5:0]              buf_word_index,
	output logic [31:0]             out_buf_word,
	output logic                    out_buf_we,
	output logic                    reader_feed,
	output logic                    punch_feed
);
	import ctcs_pkg::*;

	ctcs_state_t q;          // Registered state
	ctcs_state_t d;          // Next state

	// Words per card for a mode
	function automatic logic [5:0] words_of(input logic [1:0] m);
		case (m)
			COLUMN_IMAGE_MODE: words_of = WORDS_COL;
			ROW_IMAGE_MODE:    words_of = WORDS_ROW;
			default:           words_of = WORDS_TR;
		endcase
	endfunction

	// Per-word assembly time, less one for the down count
	function automatic logic [19:0] asm_of(input logic [1:0] m);
		asm_of = (m == ROW_IMAGE_MODE) ? ASM_RW_CYC - 20'd1 : ASM_TR_CYC - 20'd1;
	endfunction

	// Per-word disassembly time, less one
	function automatic logic [19:0] dis_of(input logic [1:0] m);
		dis_of = (m == ROW_IMAGE_MODE) ? DIS_RW_CYC - 20'd1 : DIS_TR_CYC - 20'd1;
	endfunction

	logic        wr_acc;     // APB write in access phase
	logic        rd_setup;   // APB read in setup phase
	logic        tm_busy;    // Translate/move holds the buffer
	logic        col_busy;   // Column store pause
	logic        scan_busy;  // Row scan blocks output area
	logic        alloc;      // Output area taken this cycle
	logic        release_a;  // Output area freed this cycle
	logic        mapped;     // Address hits a register
	logic [5:0]  in_last;    // Last input word index
	logic [5:0]  out_last;   // Last output word index

	assign wr_acc    = psel && penable && pwrite;
	assign rd_setup  = psel && !penable && !pwrite;
	assign tm_busy   = q.tm_cnt != 20'h0_0000;
	assign col_busy  = q.col_cnt != 20'h0_0000;
	assign scan_busy = q.scan_cnt != 20'h0_0000;
	assign mapped    = paddr == REG_FUNC || paddr == REG_STATUS || paddr == REG_CTRL;
	assign in_last   = words_of(q.rd_mode) - 6'd1;
	assign out_last  = words_of(q.punch_mode) - 6'd1;

	// Next-state logic: bus, timers, sequencer, area bookkeeping
	always_comb begin
		d           = q;
		d.feed_req  = 1'b0;
		d.punch_feed = 1'b0;
		d.out_we    = 1'b0;
		alloc       = 1'b0;
		release_a   = 1'b0;

		// Side timers count down on their own
		if (tm_busy) begin
			d.tm_cnt = q.tm_cnt - 20'd1;
		end
		if (col_busy) begin
			d.col_cnt = q.col_cnt - 20'd1;
		end
		if (scan_busy) begin
			d.scan_cnt = q.scan_cnt - 20'd1;
		end
		if (mech.tm_start) begin
			d.tm_cnt = (q.rd_mode == CTCS_TRANSLATE) ? TM_T_CYC : TM_I_CYC;
		end
		if (mech.col_store) begin
			d.col_cnt = 20'(COLST_CYC);
		end
		if (mech.row_scan && mech.pv_active) begin
			d.scan_cnt = SCAN_BLK_CYC;
		end

		// Read data is captured in setup so it leaves a flop
		if (rd_setup) begin
			case (paddr)
				REG_STATUS: d.prdata = {16'h0000, q.skip, q.st != S_IDLE, q.word_cnt,
					q.free, 1'b0, q.irq, q.status};
				REG_CTRL:   d.prdata = {30'h0000_0000, q.rd_mode};
				default:    d.prdata = 32'h0000_0000;
			endcase
		end
		// A FUNC write while the sequencer is busy, or an unknown address, is an error
		if (psel && !penable) begin
			d.pslverr = !mapped || (pwrite && paddr == REG_FUNC && q.st != S_IDLE);
		end

		// Software writes
		if (wr_acc && !q.pslverr) begin
			case (paddr)
				REG_FUNC: begin
					d.func    = pwdata[2:0];
					d.fintr   = pwdata[3];
					d.fmode   = pwdata[5:4];
					d.out_req = 1'b0;
					d.cnt     = 20'(DECODE_CYC - 1);
					d.st      = S_DECODE;
				end
				REG_STATUS: begin
					d.status = SC_NONE;
					d.irq    = 1'b0;
				end
				REG_CTRL: d.rd_mode = pwdata[1:0];
				default: d.status = q.status;
			endcase
		end

		// Sequencer
		case (q.st)
			S_IDLE: begin
				d.word_cnt = 6'd0;
			end
			S_DECODE: begin
				if (q.cnt != 20'h0_0000) begin
					d.cnt = q.cnt - 20'd1;
				end else begin
					d.fed = 1'b0;
					case (q.func)
						FN_FILL: begin
							d.prev_fill = 1'b1;
							d.st        = S_IN_WAIT;
						end
						FN_NOTRIP: begin
							d.fed = 1'b1;
							if (!mech.in_area_full && mech.sense_empty && !mech.read_active
								&& q.prev_fill) begin
								d.status = SC_IMPROPER;
								d.st     = S_IDLE;
							end else begin
								d.st = S_IN_WAIT;
							end
						end
						FN_TRIP: begin
							d.prev_fill = 1'b0;
							d.feed_req  = 1'b1;
							d.st        = S_IDLE;
						end
						FN_COND: begin
							d.cnt = 20'(COND_CYC - 1);
							d.st  = S_CP_COND;
						end
						FN_PUNCH: d.st = S_OUT_WAIT;
						default:  d.st = S_IDLE;
					endcase
				end
			end
			S_IN_WAIT: begin
				if (mech.pv_active || tm_busy) begin
					d.st = S_IN_WAIT;
				end else if (mech.in_area_full) begin
					d.cnt = asm_of(q.rd_mode);
					d.st  = S_IN_ASM;
				end else if (!q.fed) begin
					d.feed_req = 1'b1;
					d.fed      = 1'b1;
				end
			end
			S_IN_ASM: begin
				if (!tm_busy && !col_busy) begin
					if (q.cnt == 20'h0_0000) begin
						d.in_data = in_buf_word;
						d.in_req  = 1'b1;
						d.st      = S_IN_REQ;
					end else begin
						d.cnt = q.cnt - 20'd1;
					end
				end
			end
			S_IN_REQ: begin
				if (input_word_ack) begin
					d.in_req = 1'b0;
					if (q.word_cnt == in_last) begin
						d.status = SC_IN_DONE;
						d.st     = S_IDLE;
					end else begin
						d.word_cnt = q.word_cnt + 6'd1;
						d.cnt      = asm_of(q.rd_mode);
						d.st       = S_IN_ASM;
					end
				end
			end
			S_CP_COND: begin
				if (q.cnt != 20'h0_0000) begin
					d.cnt = q.cnt - 20'd1;
				end else begin
					d.punch_mode = q.fmode;
					d.st         = S_IDLE;
					if (q.fintr) begin
						d.status = SC_COND;
						d.irq    = 1'b1;
					end else begin
						d.out_req = 1'b1;
					end
				end
			end
			S_OUT_WAIT: begin
				if (!mech.fr_pending && !mech.read_active && !tm_busy
					&& q.free != 2'd0) begin
					d.out_req = 1'b1;
					d.st      = S_OUT_REQ;
				end
			end
			S_OUT_REQ: begin
				if (output_word_ack) begin
					d.out_data = output_word_data;
					d.out_req  = 1'b0;
					d.cnt      = dis_of(q.punch_mode);
					d.st       = S_OUT_DIS;
				end
			end
			S_OUT_DIS: begin
				if (!scan_busy) begin
					if (q.cnt != 20'h0_0000) begin
						d.cnt = q.cnt - 20'd1;
					end else begin
						d.out_we = 1'b1;
						if (q.word_cnt == out_last) begin
							alloc        = 1'b1;
							d.punch_feed = 1'b1;
							d.status     = SC_OUT_DONE;
							d.irq        = q.fintr;
							d.st         = S_IDLE;
						end else begin
							d.word_cnt = q.word_cnt + 6'd1;
							d.out_req  = 1'b1;
							d.st       = S_OUT_REQ;
						end
					end
				end
			end
			default: d.st = S_IDLE;
		endcase

		if (mech.pv_done) begin
			if (mech.pv_err && mech.pv_first && mech.auto_rec) begin
				d.skip = SKIP_RECOV;
			end else if (q.skip != 2'd0) begin
				d.skip = q.skip - 2'd1;
			end else begin
				release_a = !mech.pv_err;
			end
		end
		if (mech.mclr) begin
			d.free = AREAS_ALL;
			d.skip = 2'd0;
		end else if (release_a && !alloc && q.free != AREAS_ALL) begin
			d.free = q.free + 2'd1;
		end else if (alloc && !release_a) begin
			d.free = q.free - 2'd1;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q       <= '0;
			q.st    <= S_IDLE;
			q.free  <= AREAS_ALL;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state; pready tied high, pslverr gated to the access phase
	assign prdata              = q.prdata;
	assign pready              = 1'b1;
	assign pslverr             = psel && penable && q.pslverr;
	assign input_word_request  = q.in_req;
	assign input_word_data     = q.in_data;
	assign output_word_request = q.out_req;
	assign host_interrupt_line = q.irq;
	assign buf_word_index      = q.word_cnt;
	assign out_buf_word        = q.out_data;
	assign out_buf_we          = q.out_we;
	assign reader_feed         = q.feed_req;
	assign punch_feed          = q.punch_feed;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	dec_done_a: assert property ((q.st == S_DECODE && q.cnt == 20'h0_0000) |=>
		q.st != S_DECODE) else $error("decode overran");
	tm_hold_a: assert property ((q.st == S_IN_ASM && tm_busy) |=>
		q.cnt == $past(q.cnt) && !q.in_req) else $error("assembly ran during move");
	col_hold_a: assert property ((q.st == S_IN_ASM && col_busy && !tm_busy) |=>
		q.cnt == $past(q.cnt)) else $error("assembly ran during column store");
	scan_stall_a: assert property ((q.st == S_OUT_DIS && scan_busy) |=>
		q.st == S_OUT_DIS && q.cnt == $past(q.cnt)) else $error("disassembly ran in scan");
	in_hold_a: assert property ((q.in_req && !input_word_ack) |=>
		q.in_req && $stable(q.in_data)) else $error("input word dropped early");
	out_gate_a: assert property ((q.st == S_OUT_WAIT && d.st == S_OUT_REQ) |->
		q.free != 2'd0 && !mech.read_active && !mech.fr_pending)
		else $error("output transfer started badly");
	mclr_free_a: assert property (mech.mclr |=> q.free == AREAS_ALL && q.skip == 2'd0)
		else $error("clear did not free areas");
	recov_skip_a: assert property ((mech.pv_done && mech.pv_err && mech.pv_first
		&& mech.auto_rec && !mech.mclr) |=> q.skip == SKIP_RECOV && q.free == $past(q.free)
		- {1'b0, $past(alloc)}) else $error("recovery skip wrong");
	improper_a: assert property ((q.st == S_DECODE && q.cnt == 20'h0_0000
		&& q.func == FN_NOTRIP && q.prev_fill && mech.sense_empty && !mech.in_area_full
		&& !mech.read_active) |=> q.status == SC_IMPROPER && q.st == S_IDLE)
		else $error("improper status missing");
	cond_end_a: assert property ((q.st == S_CP_COND && q.cnt == 20'h0_0000) |=>
		q.st == S_IDLE && (q.irq || q.out_req)) else $error("condition did not finish");
	word_cap_a: assert property (q.word_cnt <= 6'd35)
		else $error("word count overrun");

	in_card_c: cover property (q.st == S_IN_REQ && input_word_ack && q.word_cnt == in_last);
	out_card_c: cover property (q.punch_feed);
	preempt_c: cover property (q.st == S_IN_ASM && tm_busy);
	scan_c: cover property (q.st == S_OUT_DIS && scan_busy);

endmodule // ctcs_top

// >>> test/ctcs_host_model.sv
// Purpose: Processor channel model answering input and output word requests.
// Assumes: Requests are levels from flops; one ack pulse answers one word.
// Notes: Answers after RESP_CYC cycles, the minimum response, or slower.
`timescale 1ns/1ps

module ctcs_host_model #(
	parameter int RESP_CYC = 375
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Input words
	input  wire logic        input_word_request,
	output logic             input_word_ack,
	// Output words
	input  wire logic        output_word_request,
	output logic             output_word_ack,
	output logic [31:0]      output_word_data,
	// Words taken so far
	output int               in_cnt
);
	int          in_wait;   // Cycles the input word has stood
	int          out_wait;  // Cycles the output request has stood
	logic [31:0] last_q;    // Last word sent

	// One process answers both directions; data is garbage between words
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_word_ack   <= 1'b0;
			output_word_ack  <= 1'b0;
			output_word_data <= 32'hFFFF_FFFF;
			last_q           <= 32'h0000_0000;
			in_wait          <= 0;
			out_wait         <= 0;
			in_cnt           <= 0;
		end else begin
			input_word_ack   <= 1'b0;
			output_word_ack  <= 1'b0;
			output_word_data <= ~last_q;
			if (input_word_request && !input_word_ack) begin
				in_wait <= in_wait + 1;
				if (in_wait >= RESP_CYC) begin
					input_word_ack <= 1'b1;
					in_wait        <= 0;
					in_cnt         <= in_cnt + 1;
				end
			end else begin
				in_wait <= 0;
			end
			if (output_word_request && !output_word_ack) begin
				out_wait <= out_wait + 1;
				if (out_wait >= RESP_CYC) begin
					output_word_ack  <= 1'b1;
					output_word_data <= last_q + 32'h0000_1001;
					last_q           <= last_q + 32'h0000_1001;
					out_wait         <= 0;
				end
			end else begin
				out_wait <= 0;
			end
		end
	end
endmodule // ctcs_host_model

// >>> test/testbench.sv
// Purpose: Self-checking bench for the card transfer cycle sequencer.
// Assumes: Shortened timer parameters; host model answers at 3 us.
// Notes: Register rows first, then input, condition and punch sequences.
`timescale 1ns/1ps

module testbench;
	import ctcs_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite;  // Bus master side
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, e;
	logic        in_req, in_ack, out_req, out_ack, irq, out_we, rfeed, pfeed;
	logic [31:0] in_data, out_data, out_buf, in_buf;
	logic [5:0]  idx;
	ctcs_mech_t  mech;                                   // Mechanism stand-in
	int          miscompares, compares, in_cnt, we_cnt, wtot, n, i;

	// Register rows: address, write, data, expected read, expected error
	typedef struct {logic [11:0] a; logic w; logic [31:0] d, x; logic er;} ctcs_row_t;
	ctcs_row_t rows[6] = '{
		'{REG_STATUS, 1'b0, 32'h0, 32'h0000_0060, 1'b0},
		'{REG_CTRL, 1'b1, 32'h0000_0002, 32'h0, 1'b0},
		'{REG_CTRL, 1'b0, 32'h0, 32'h0000_0002, 1'b0},
		'{REG_CTRL, 1'b1, 32'h0, 32'h0, 1'b0},
		'{12'h00C, 1'b0, 32'h0, 32'h0, 1'b1},
		'{12'h010, 1'b1, 32'h0000_0001, 32'h0, 1'b1}};

	// Buffer memory returns a word tied to its index
	assign in_buf = {26'h0, idx} ^ 32'hA5A5_0000;

	// Row-mode timers keep their full defaults; no row-mode card is run
	ctcs_top #(.ASM_TR_CYC(20'd20), .DIS_TR_CYC(20'd30), .SCAN_BLK_CYC(20'd25),
		.TM_T_CYC(20'd50), .TM_I_CYC(20'd80)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.input_word_request(in_req), .input_word_data(in_data),
		.input_word_ack(in_ack), .output_word_request(out_req),
		.output_word_ack(out_ack), .output_word_data(out_data),
		.host_interrupt_line(irq), .mech(mech), .in_buf_word(in_buf),
		.buf_word_index(idx), .out_buf_word(out_buf), .out_buf_we(out_we),
		.reader_feed(rfeed), .punch_feed(pfeed));

	ctcs_host_model host_u (.pclk(pclk), .presetn(presetn),
		.input_word_request(in_req), .input_word_ack(in_ack),
		.output_word_request(out_req), .output_word_ack(out_ack),
		.output_word_data(out_data), .in_cnt(in_cnt));

	// Clock at 8 ns
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Count buffer loads; host numbers its words, buffer words follow their index
	always @(posedge pclk) begin
		if (out_we === 1'b1) begin
			we_cnt++;
			wtot++;
			chk("punch word", out_buf, 32'h0000_1001 * wtot);
		end
		if (in_req === 1'b1 && in_ack === 1'b1) begin
			chk("input word", in_data, {26'h0, 6'((in_cnt - 1) % 14)} ^ 32'hA5A5_0000);
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; hold until pready is seen high
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return in_req;
			1: return out_req;
			2: return irq;
			3: return pfeed;
			4: return rfeed;
			5: return !out_req;
			6: return out_we;
			default: return logic'(in_cnt >= s);
		endcase
	endfunction

	// Bounded wait for a signal; n is cycles spent
	task automatic wait_hi(input int s, input int lim);
		n = 0;
		while (sig(s) !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask

	task automatic mech_pulse(input int f);
		@(posedge pclk);
		mech.pv_done <= 1'b1;
		mech.pv_err <= (f == 1); mech.pv_first <= (f == 1); mech.auto_rec <= (f == 1);
		mech.mclr <= (f == 2);
		@(posedge pclk);
		mech.pv_done <= 1'b0; mech.mclr <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	// Punch a translate card; fr_pending holds it off first
	task automatic do_punch();
		we_cnt = 0;
		mech.fr_pending <= 1'b1;
		apb(REG_FUNC, 1'b1, {29'h0, FN_PUNCH});
		repeat (2000) @(posedge pclk);
		chk("held loads", we_cnt, 0);
		mech.fr_pending <= 1'b0;
		// Row scan lands in the first disassembly and must stall it
		wait_hi(1, 3000);
		wait_hi(5, 1000);
		mech.row_scan <= 1'b1; mech.pv_active <= 1'b1;
		@(posedge pclk);
		mech.row_scan <= 1'b0; mech.pv_active <= 1'b0;
		wait_hi(6, 200);
		chk("scan stall", n >= 28 + 25 && n <= 30 + 25, 1);
		wait_hi(3, 20000);
		repeat (3) @(posedge pclk);
		chk("loads at feed", we_cnt, 14);
		apb(REG_STATUS, 1'b0, 32'h0);
		chk("punch status", {r[6:5], r[2:0]}, {2'd2, SC_OUT_DONE});
	endtask

	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Watchdog over the expected run length
	initial begin
		#(8 * 95000);
		miscompares++;
		close_out();
	end

	initial begin
		miscompares = 0; compares = 0; we_cnt = 0; wtot = 0;
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; mech = '0; mech.sense_empty = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Register rows
		foreach (rows[k]) begin
			apb(rows[k].a, rows[k].w, rows[k].d);
			if (!rows[k].w) chk("read data", r, rows[k].x);
			chk("slave error", e, rows[k].er);
		end
		$display("register rows done");
		// Input held off by punch/verify, then started promptly
		mech.pv_active <= 1'b1; mech.in_area_full <= 1'b1;
		apb(REG_FUNC, 1'b1, {29'h0, FN_FILL});
		wait_hi(0, 2000);
		chk("held input", n, 2000);
		mech.pv_active <= 1'b0;
		wait_hi(0, 40);
		chk("input start", n < 40, 1);
		wait_hi(14, 9000);
		repeat (3) @(posedge pclk);
		apb(REG_STATUS, 1'b0, 32'h0);
		chk("input done", r[2:0], SC_IN_DONE);
		$display("input transfer done");
		// Fill with empty areas feeds a card first
		mech.in_area_full <= 1'b0;
		apb(REG_FUNC, 1'b1, {29'h0, FN_FILL});
		wait_hi(4, 1300);
		chk("feed issued", n < 1300, 1);
		// Move starts as the card lands: assembly waits it out
		mech.in_area_full <= 1'b1; mech.tm_start <= 1'b1;
		@(posedge pclk);
		mech.tm_start <= 1'b0;
		wait_hi(0, 200);
		chk("move preempt", n >= 20 + 50 && n <= 22 + 50, 1);
		mech.col_store <= 1'b1;
		@(posedge pclk);
		mech.col_store <= 1'b0;
		wait_hi(28, 9000);
		chk("fill words", in_cnt, 28);
		// No-trip after fill with nothing sensed
		mech.in_area_full <= 1'b0;
		repeat (5) @(posedge pclk);
		apb(REG_FUNC, 1'b1, {29'h0, FN_NOTRIP});
		repeat (1400) @(posedge pclk);
		apb(REG_STATUS, 1'b0, 32'h0);
		chk("improper", r[2:0], SC_IMPROPER);
		$display("fill and no-trip done");
		// Condition punch without then with interrupt
		apb(REG_FUNC, 1'b1, {29'h0, FN_COND});
		wait_hi(1, 1400);
		chk("cond time", n > DECODE_CYC && n <= DECODE_CYC + COND_CYC + 1, 1);
		apb(REG_FUNC, 1'b1, {28'h0, 1'b1, FN_COND});
		wait_hi(2, 1400);
		chk("cond irq time", n > DECODE_CYC && n <= DECODE_CYC + COND_CYC + 1, 1);
		apb(REG_STATUS, 1'b0, 32'h0);
		chk("cond status", r[3:0], {1'b1, SC_COND});
		apb(REG_STATUS, 1'b1, 32'h0);
		@(posedge pclk);
		chk("irq cleared", irq, 1'b0);
		$display("condition done");
		// Punch, master clear, punch, then recovery accounting
		do_punch();
		mech_pulse(2);
		apb(REG_STATUS, 1'b0, 32'h0);
		chk("clear areas", r[6:5], AREAS_ALL);
		do_punch();
		for (i = 1; i >= 0; i--) begin
			mech_pulse(i);
			apb(REG_STATUS, 1'b0, 32'h0);
			chk("skipped areas", r[6:5], 2'd2);
		end
		mech_pulse(0);
		mech_pulse(0);
		apb(REG_STATUS, 1'b0, 32'h0);
		chk("released area", r[6:5], AREAS_ALL);
		$display("punch done");
		// Reset in mid-function: sequencer idle, all areas free
		apb(REG_FUNC, 1'b1, {29'h0, FN_COND});
		repeat (5) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(REG_STATUS, 1'b0, 32'h0);
		chk("reset status", r, 32'h0000_0060);
		$display("reset done");
		close_out();
	end
endmodule // testbench
